/* File: hw/timer_ctrl_pkg.sv */
// Constants for the timer control register group
package timer_ctrl_pkg;

	// Register indexes; byte address is four times the index
	localparam logic [5:0] IDX_ENABLE_CONTROL   = 6'h00;
	localparam logic [5:0] IDX_MODE_CONTROL     = 6'h01;
	localparam logic [5:0] IDX_OUTPUT_VALUE     = 6'h02;
	localparam logic [5:0] IDX_SPLIT_CONTROL    = 6'h03;
	localparam logic [5:0] IDX_COMMAND_CLEAR    = 6'h04;
	localparam logic [5:0] IDX_COMMAND_SET      = 6'h05;
	localparam logic [5:0] IDX_VALID_CLEAR      = 6'h06;
	localparam logic [5:0] IDX_VALID_SET        = 6'h07;

	// Field positions
	localparam int ENABLE_BIT       = 0;
	localparam int SPLIT_BIT        = 0;
	localparam int DIR_BIT          = 0;
	localparam int LOCK_BIT         = 1;
	localparam int CMD_LSB          = 2;
	localparam int CMD_MSB          = 3;
	localparam int MODE_LSB         = 0;
	localparam int MODE_MSB         = 2;
	localparam int CHANNELS         = 3;
	localparam int VALID_FLAGS      = 4;

	// Reset values
	localparam logic [7:0] REG_RESET  = 8'h00;
	localparam logic [2:0] MODE_RESET = 3'h0;

	typedef enum logic [1:0] {
		CMD_NONE    = 2'h0,
		CMD_UPDATE  = 2'h1,
		CMD_RESTART = 2'h2,
		CMD_HARD    = 2'h3
	} command_t;

	typedef enum logic [2:0] {
		MODE_NORMAL           = 3'h0,
		MODE_FREQUENCY_MODE   = 3'h1,
		MODE_ONE_SLOPE_PWM    = 3'h3,
		MODE_TWO_SLOPE_TOP    = 3'h5,
		MODE_TWO_SLOPE_BOTH   = 3'h6,
		MODE_TWO_SLOPE_BOTTOM = 3'h7
	} waveform_mode_t;

endpackage : timer_ctrl_pkg

/* File: hw/waveform_mode_decode.sv */
// Decoder of the waveform mode field
`timescale 1ns/1ns
module waveform_mode_decode
(
	input  wire logic [2:0] waveform_mode,
	output logic            mode_reserved,
	output logic            top_is_period,
	output logic            update_at_bottom,
	output logic            two_slope,
	output logic            down_start
);
	import timer_ctrl_pkg::*;
	always_comb
	begin
		mode_reserved    = 1'b0;
		top_is_period    = 1'b1;
		update_at_bottom = 1'b0;
		two_slope        = 1'b0;
		down_start       = 1'b0;
		case (waveform_mode)
			MODE_NORMAL:
			begin
				update_at_bottom = 1'b0;
			end
			MODE_FREQUENCY_MODE:
			begin
				top_is_period = 1'b0; // [RL14]
			end
			MODE_ONE_SLOPE_PWM:
			begin
				update_at_bottom = 1'b1; // [RL14]
			end
			MODE_TWO_SLOPE_TOP, MODE_TWO_SLOPE_BOTH, MODE_TWO_SLOPE_BOTTOM:
			begin
				update_at_bottom = 1'b1; // [RL15]
				two_slope        = 1'b1;
			end
			default:
			begin
				mode_reserved = 1'b1; // [RL14]
			end
		endcase
	end
endmodule : waveform_mode_decode

/* File: hw/timer_control_registers.sv */
// Control register group of a 16-bit timer with APB access
// What this block does
// [RL1] Output value bits force waveform outputs only while the timer is disabled.
// [RL2] Split select bit makes two 8-bit counters; the register map stays the same.
// [RL3] Writing one to command-status clear register clears that bit.
// [RL4] Writing one to command-status set register sets that bit.
// [RL5] Both command-status registers read the same current bits.
// [RL6] The two-bit command field always reads zero.
// [RL7] Command 0 none, 1 force update, 2 restart, 3 hard reset.
// [RL8] Hard reset command is ignored while the timer is enabled.
// [RL9] Lock clear: buffers transfer as soon as an update condition occurs.
// [RL10] Lock set: no buffer transfer even on an update condition.
// [RL11] Direction bit is driven by hardware yet stays software writable.
// [RL12] Direction zero counts up, one counts down.
// [RL13] Valid-clear register clears period and three compare valid flags by ones.
// [RL14] Mode decode: 0,1,3,5,6,7 defined; 2 and 4 reserved.
// [RL15] Dual-slope modes use period as top and update at bottom.
// [RL16] Each valid flag sets when its buffer register is written.
// [RL17] Valid flags clear when an update transfers the buffers, except a flag whose buffer or valid-set bit is written in that cycle.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ns
module timer_control_registers
#(
	parameter int ADDR_WIDTH = 8
)
(
	input  wire logic                   clock,
	input  wire logic                   rst_b,
	input  wire logic                   clock_enable,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [ADDR_WIDTH-1:0]  paddr,
	input  wire logic [31:0]            pwdata,
	input  wire logic [3:0]             pstrb,
	output logic [31:0]                 prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic                   update_event,
	input  wire logic                   period_buffer_write,
	input  wire logic [timer_ctrl_pkg::CHANNELS-1:0] compare_buffer_write,
	input  wire logic                   dir_hw_load,
	input  wire logic                   dir_hw_value,
	input  wire logic [timer_ctrl_pkg::CHANNELS-1:0] wave_gen,
	output logic [timer_ctrl_pkg::CHANNELS-1:0]      wave_out,
	output logic                        timer_enable,
	output logic                        dual_8bit_select,
	output logic                        count_down,
	output logic                        update_lock,
	output logic                        transfer_buffers,
	output logic                        restart_pulse,
	output logic                        hard_reset_pulse,
	output logic [2:0]                  waveform_mode,
	output logic                        mode_reserved,
	output logic                        top_is_period,
	output logic                        update_at_bottom,
	output logic                        two_slope,
	output logic                        period_buffer_valid,
	output logic                        compare0_buffer_valid,
	output logic                        compare1_buffer_valid,
	output logic                        compare2_buffer_valid
);
	import timer_ctrl_pkg::*;

	logic [CHANNELS-1:0]    output_value;
	logic [VALID_FLAGS-1:0] buffer_valid;
	logic [VALID_FLAGS-1:0] buffer_write;
	logic [5:0]             index;
	logic                   setup;
	logic                   access;
	logic                   write_now;
	logic                   mapped;
	logic [7:0]             wbyte;
	logic [7:0]             next_read;
	logic [1:0]             command;
	logic                   update_request;
	logic                   next_reserved;
	logic                   next_top_period;
	logic                   next_at_bottom;
	logic                   next_two_slope;

	assign index     = paddr[7:2];
	assign setup     = psel && !penable;
	assign access    = psel && penable && pready;
	// Writes to unmapped or misaligned addresses are dropped
	assign write_now = clock_enable && access && pwrite && pstrb[0] && mapped;
	assign wbyte     = pwdata[7:0];
	assign command   = wbyte[CMD_MSB:CMD_LSB];
	assign mapped    = (index <= IDX_VALID_SET) && (paddr[1:0] == 2'b00);

	// Flag order: period first, then the compare channels
	assign buffer_write = {compare_buffer_write, period_buffer_write};

	assign period_buffer_valid   = buffer_valid[0];
	assign compare0_buffer_valid = buffer_valid[1];
	assign compare1_buffer_valid = buffer_valid[2];
	assign compare2_buffer_valid = buffer_valid[3];

	// A forced update arrives through either command register
	assign update_request = update_event
		|| (write_now && (index == IDX_COMMAND_SET || index == IDX_COMMAND_CLEAR)
			&& command == CMD_UPDATE); // [RL7]

	waveform_mode_decode decode_mode (
		.waveform_mode    (waveform_mode),
		.mode_reserved    (next_reserved),
		.top_is_period    (next_top_period),
		.update_at_bottom (next_at_bottom),
		.two_slope        (next_two_slope),
		.down_start       ()
	);

	// APB answer: ready in the first access cycle, data captured at setup
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end
		else if (clock_enable)
		begin
			pready  <= setup;
			pslverr <= setup && !mapped;
			if (setup && !pwrite)
			begin
				prdata <= {24'h000000, next_read};
			end
		end
	end

	always_comb
	begin
		next_read = 8'h00;
		case (index)
			IDX_ENABLE_CONTROL:
			begin
				next_read[ENABLE_BIT] = timer_enable;
			end
			IDX_MODE_CONTROL:
			begin
				next_read[MODE_MSB:MODE_LSB] = waveform_mode;
			end
			IDX_OUTPUT_VALUE:
			begin
				next_read[CHANNELS-1:0] = output_value;
			end
			IDX_SPLIT_CONTROL:
			begin
				next_read[SPLIT_BIT] = dual_8bit_select;
			end
			IDX_COMMAND_CLEAR, IDX_COMMAND_SET:
			begin
				next_read[CMD_MSB:CMD_LSB] = 2'b00; // [RL6]
				next_read[LOCK_BIT] = update_lock; // [RL5]
				next_read[DIR_BIT]  = count_down;  // [RL5]
			end
			IDX_VALID_CLEAR, IDX_VALID_SET:
			begin
				next_read[VALID_FLAGS-1:0] = buffer_valid;
			end
			default:
			begin
				next_read = 8'h00;
			end
		endcase
		if (!mapped)
		begin
			next_read = 8'h00;
		end
	end

	// Plain control registers
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			timer_enable     <= 1'b0;
			waveform_mode    <= MODE_RESET;
			output_value     <= '0;
			dual_8bit_select <= 1'b0;
		end
		else if (write_now)
		begin
			case (index)
				IDX_ENABLE_CONTROL:
				begin
					timer_enable <= wbyte[ENABLE_BIT];
				end
				IDX_MODE_CONTROL:
				begin
					waveform_mode <= wbyte[MODE_MSB:MODE_LSB];
				end
				IDX_OUTPUT_VALUE:
				begin
					output_value <= wbyte[CHANNELS-1:0];
				end
				IDX_SPLIT_CONTROL:
				begin
					dual_8bit_select <= wbyte[SPLIT_BIT]; // [RL2]
				end
				default:
				begin
					timer_enable <= timer_enable;
				end
			endcase
		end
	end

	// Registered mode decode
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mode_reserved    <= 1'b0;
			top_is_period    <= 1'b1;
			update_at_bottom <= 1'b0;
			two_slope        <= 1'b0;
		end
		else if (clock_enable)
		begin
			mode_reserved    <= next_reserved;    // [RL14]
			top_is_period    <= next_top_period;  // [RL15]
			update_at_bottom <= next_at_bottom;   // [RL15]
			two_slope        <= next_two_slope;
		end
	end

	// Waveform outputs: software value while stopped, generator while running
	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++)
		begin : g_wave
			always_ff @(posedge clock or negedge rst_b)
			begin
				if (!rst_b)
				begin
					wave_out[ch] <= 1'b0;
				end
				else if (clock_enable)
				begin
					wave_out[ch] <= timer_enable ? wave_gen[ch] : output_value[ch]; // [RL1]
				end
			end
		end
	endgenerate

	// Lock and direction: software set/clear beats the hardware direction load
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			update_lock <= 1'b0;
			count_down  <= 1'b0;
		end
		else if (clock_enable)
		begin
			if (write_now && index == IDX_COMMAND_SET)
			begin
				update_lock <= update_lock | wbyte[LOCK_BIT]; // [RL4]
				count_down  <= count_down | wbyte[DIR_BIT];   // [RL11]
			end
			else if (write_now && index == IDX_COMMAND_CLEAR)
			begin
				update_lock <= update_lock & ~wbyte[LOCK_BIT]; // [RL3]
				count_down  <= count_down & ~wbyte[DIR_BIT];   // [RL12]
			end
			else if (dir_hw_load)
			begin
				count_down <= dir_hw_value; // [RL11]
			end
		end
	end

	// Command pulses, one cycle each
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			restart_pulse    <= 1'b0;
			hard_reset_pulse <= 1'b0;
		end
		else if (clock_enable)
		begin
			restart_pulse    <= 1'b0;
			hard_reset_pulse <= 1'b0;
			if (write_now && (index == IDX_COMMAND_SET || index == IDX_COMMAND_CLEAR))
			begin
				restart_pulse    <= command == CMD_RESTART;                 // [RL7]
				hard_reset_pulse <= command == CMD_HARD && !timer_enable;   // [RL8]
			end
		end
	end

	// Buffer transfer happens only when the lock is clear
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			transfer_buffers <= 1'b0;
		end
		else if (clock_enable)
		begin
			transfer_buffers <= update_request && !update_lock; // [RL9] [RL10]
		end
	end

	// Buffer valid flags; a new buffer write wins over any clear
	generate
		for (ch = 0; ch < VALID_FLAGS; ch++)
		begin : g_valid
			always_ff @(posedge clock or negedge rst_b)
			begin
				if (!rst_b)
				begin
					buffer_valid[ch] <= 1'b0;
				end
				else if (clock_enable)
				begin
					if (buffer_write[ch])
					begin
						buffer_valid[ch] <= 1'b1; // [RL16]
					end
					else if (write_now && index == IDX_VALID_SET && wbyte[ch])
					begin
						buffer_valid[ch] <= 1'b1;
					end
					else if (write_now && index == IDX_VALID_CLEAR && wbyte[ch])
					begin
						buffer_valid[ch] <= 1'b0; // [RL13]
					end
					else if (update_request && !update_lock)
					begin
						buffer_valid[ch] <= 1'b0; // [RL17]
					end
				end
			end
		end
	endgenerate

endmodule : timer_control_registers

/* File: test/timer_control_registers_monitor.sv */
// Assertion checker for the timer control registers
`timescale 1ns/1ns
module timer_control_registers_monitor
#(
	parameter int ADDR_WIDTH = 8
)
(
	input wire logic                  clock,
	input wire logic                  rst_b,
	input wire logic                  clock_enable,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0]           pwdata,
	input wire logic [3:0]            pstrb,
	input wire logic                  pready,
	input wire logic                  update_event,
	input wire logic                  period_buffer_write,
	input wire logic                  timer_enable,
	input wire logic                  count_down,
	input wire logic                  update_lock,
	input wire logic                  transfer_buffers,
	input wire logic                  restart_pulse,
	input wire logic                  hard_reset_pulse,
	input wire logic [2:0]            waveform_mode,
	input wire logic                  mode_reserved,
	input wire logic                  top_is_period,
	input wire logic                  update_at_bottom,
	input wire logic                  two_slope,
	input wire logic                  period_buffer_valid
);
	import timer_ctrl_pkg::*;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	wire apb_wr  = psel && penable && pready && pwrite && pstrb[0] && clock_enable;
	wire cmd_reg = paddr[ADDR_WIDTH-1:3] == 'h2 && paddr[1:0] == 2'b00;
	wire set_reg = paddr == 'h1C;
	wire upd     = update_event && !update_lock && clock_enable;
	sequence s_setup;
		psel && !penable && clock_enable;
	endsequence
	sequence s_answer;
		pready ##1 !pready;
	endsequence
	a_apb_answer: assert property (s_setup |=> s_answer)
		else $error("ready not a single pulse after setup");
	a_restart_cmd: assert property (
		apb_wr && cmd_reg && pwdata[3:2] == 2'h2 |=> restart_pulse)
		else $error("restart command gave no pulse");
	a_hard_blocked: assert property (timer_enable && clock_enable |=> !hard_reset_pulse)
		else $error("hard reset while enabled");
	a_dir_set: assert property (apb_wr && paddr == 'h14 && pwdata[0] |=> count_down)
		else $error("direction not set");
	a_update_xfer: assert property (upd |=> transfer_buffers)
		else $error("update gave no transfer");
	a_lock_holds: assert property (update_lock && clock_enable |=> !transfer_buffers)
		else $error("transfer while locked");
	a_valid_set: assert property (
		period_buffer_write && clock_enable |=> period_buffer_valid)
		else $error("valid flag not set");
	a_valid_clear: assert property (
		upd && !period_buffer_write && !(apb_wr && set_reg && pwdata[0])
		|=> !period_buffer_valid)
		else $error("valid flag not cleared");
	a_mode_decode: assert property (clock_enable |=>
		mode_reserved == ($past(waveform_mode) inside {3'h2, 3'h4}))
		else $error("reserved mode decode wrong");
	a_slope_top: assert property (two_slope |-> top_is_period && update_at_bottom)
		else $error("dual-slope top or update wrong");
endmodule : timer_control_registers_monitor

bind timer_control_registers timer_control_registers_monitor #(.ADDR_WIDTH(ADDR_WIDTH))
	timer_control_registers_monitor_inst (.clock, .rst_b, .clock_enable, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pstrb, .pready, .update_event, .period_buffer_write, .timer_enable,
	.count_down, .update_lock, .transfer_buffers, .restart_pulse, .hard_reset_pulse,
	.waveform_mode, .mode_reserved, .top_is_period, .update_at_bottom, .two_slope,
	.period_buffer_valid);

/* File: test/timer_control_registers_bench.sv */
// Self-checking bench for the timer control registers
`timescale 1ns/1ns
module timer_control_registers_bench;
	import timer_ctrl_pkg::*;
	logic        clock, rst_b, clock_enable, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd_data;
	logic [3:0]  pstrb;
	logic        update_event, period_buffer_write, dir_hw_load, dir_hw_value;
	logic [2:0]  compare_buffer_write, wave_gen, wave_out, waveform_mode;
	logic        timer_enable, dual_8bit_select, count_down, update_lock, transfer_buffers;
	logic        restart_pulse, hard_reset_pulse, mode_reserved, top_is_period;
	logic        update_at_bottom, two_slope, period_buffer_valid;
	logic        compare0_buffer_valid, compare1_buffer_valid, compare2_buffer_valid;
	int          n_mismatch, compares, n_xfer, n_restart, n_hard, x0, r0, h0;
	wire [3:0]   flags = {compare2_buffer_valid, compare1_buffer_valid,
		compare0_buffer_valid, period_buffer_valid};

	timer_control_registers timer_control_registers_inst (.clock, .rst_b, .clock_enable,
		.psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
		.update_event, .period_buffer_write, .compare_buffer_write, .dir_hw_load,
		.dir_hw_value, .wave_gen, .wave_out, .timer_enable, .dual_8bit_select, .count_down,
		.update_lock, .transfer_buffers, .restart_pulse, .hard_reset_pulse, .waveform_mode,
		.mode_reserved, .top_is_period, .update_at_bottom, .two_slope, .period_buffer_valid,
		.compare0_buffer_valid, .compare1_buffer_valid, .compare2_buffer_valid);

	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	always @(posedge clock)
	begin
		n_xfer <= n_xfer + (transfer_buffers === 1'b1);
		n_restart <= n_restart + (restart_pulse === 1'b1);
		n_hard <= n_hard + (hard_reset_pulse === 1'b1);
	end

	function automatic logic [7:0] ba(input logic [5:0] i);
		return {i, 2'b00};
	endfunction : ba

	task automatic results();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Setup, access until ready, then one idle edge before the next transfer
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do
		begin
			@(posedge clock);
		end
		while (pready !== 1'b1);
		rd_data = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd_data, exp);
	endtask : rd

	task automatic ev();
		update_event <= 1'b1;
		@(posedge clock);
		update_event <= 1'b0;
		repeat (2) @(posedge clock);
	endtask : ev

	initial
	begin
		#200000;
		n_mismatch++;
		results();
	end

	initial
	begin
		{n_mismatch, compares, n_xfer, n_restart, n_hard} = '0;
		{rst_b, psel, penable, pwrite, paddr, pwdata, update_event, dir_hw_load} = '0;
		{period_buffer_write, compare_buffer_write, dir_hw_value} = '0;
		clock_enable = 1'b1;
		pstrb = 4'hF;
		wave_gen = 3'h5;
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		chk(top_is_period, 1'b1);
		for (int i = 0; i < 8; i++)
			rd(ba(6'(i)), 32'h0);
		$display("reset test done");
		apb(1'b1, ba(IDX_OUTPUT_VALUE), 32'h6);
		rd(ba(IDX_OUTPUT_VALUE), 32'h6);
		chk(wave_out, 3'h6);
		apb(1'b1, ba(IDX_ENABLE_CONTROL), 32'h1);
		@(posedge clock);
		chk(wave_out, 3'h5);
		apb(1'b1, ba(IDX_SPLIT_CONTROL), 32'h1);
		chk(dual_8bit_select, 1'b1);
		apb(1'b1, ba(IDX_COMMAND_SET), 32'h3);
		rd(ba(IDX_COMMAND_CLEAR), 32'h3);
		chk({update_lock, count_down}, 2'h3);
		apb(1'b1, ba(IDX_COMMAND_CLEAR), 32'h3);
		rd(ba(IDX_COMMAND_SET), 32'h0);
		dir_hw_value <= 1'b1;
		dir_hw_load <= 1'b1;
		@(posedge clock);
		dir_hw_load <= 1'b0;
		repeat (2) @(posedge clock);
		chk(count_down, 1'b1);
		apb(1'b1, ba(IDX_COMMAND_CLEAR), 32'h1);
		$display("control test done");
		for (int e = 1; e >= 0; e--)
		begin
			for (int c = 0; c < 4; c++)
			begin
				x0 = n_xfer;
				r0 = n_restart;
				h0 = n_hard;
				apb(1'b1, ba(e ? IDX_COMMAND_SET : IDX_COMMAND_CLEAR), 32'(c << 2));
				rd(ba(IDX_COMMAND_SET), 32'h0);
				chk(n_xfer - x0, c == 1);
				chk(n_restart - r0, c == 2);
				chk(n_hard - h0, c == 3 && e == 0);
			end
			apb(1'b1, ba(IDX_ENABLE_CONTROL), 32'h0);
		end
		$display("command test done");
		period_buffer_write <= 1'b1;
		compare_buffer_write <= 3'h7;
		@(posedge clock);
		period_buffer_write <= 1'b0;
		compare_buffer_write <= 3'h0;
		@(posedge clock);
		chk(flags, 4'hF);
		apb(1'b1, ba(IDX_COMMAND_SET), 32'h2);
		x0 = n_xfer;
		ev();
		chk(n_xfer - x0, 32'h0);
		chk(flags, 4'hF);
		apb(1'b1, ba(IDX_VALID_CLEAR), 32'h5);
		rd(ba(IDX_VALID_SET), 32'hA);
		apb(1'b1, ba(IDX_VALID_SET), 32'h5);
		rd(ba(IDX_VALID_CLEAR), 32'hF);
		apb(1'b1, ba(IDX_COMMAND_CLEAR), 32'h2);
		x0 = n_xfer;
		ev();
		chk(n_xfer - x0, 32'h1);
		chk(flags, 4'h0);
		// Clock enable low: an update and a buffer write must both be ignored
		x0 = n_xfer;
		clock_enable <= 1'b0;
		update_event <= 1'b1;
		period_buffer_write <= 1'b1;
		@(posedge clock);
		update_event <= 1'b0;
		period_buffer_write <= 1'b0;
		clock_enable <= 1'b1;
		repeat (2) @(posedge clock);
		chk(n_xfer - x0, 32'h0);
		chk(flags, 4'h0);
		$display("buffer test done");
		for (int m = 0; m < 8; m++)
		begin
			apb(1'b1, ba(IDX_MODE_CONTROL), 32'(m));
			rd(ba(IDX_MODE_CONTROL), 32'(m));
			chk(waveform_mode, 32'(m));
			chk(mode_reserved, m == 2 || m == 4);
			chk(two_slope, m > 4);
			chk({update_at_bottom, top_is_period}, {m == 3 || m > 4, m != 1});
		end
		apb(1'b0, 8'h20, 32'h0);
		chk(err, 1'b1);
		chk(rd_data, 32'h0);
		apb(1'b1, 8'h09, 32'h1);
		chk(err, 1'b1);
		pstrb <= 4'hE;
		apb(1'b1, ba(IDX_OUTPUT_VALUE), 32'h1);
		pstrb <= 4'hF;
		rd(ba(IDX_OUTPUT_VALUE), 32'h6);
		$display("mode and map test done");
		rst_b <= 1'b0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		chk(dual_8bit_select, 1'b0);
		rd(ba(IDX_MODE_CONTROL), 32'h0);
		chk(top_is_period, 1'b1);
		$display("mid-run reset test done");
		results();
	end
endmodule : timer_control_registers_bench
